// >>> rtl/mgc_pkg.sv
// Constants, field layout and types of the management general control register block.
// Assumes a 32-bit APB slave with byte addresses; all offsets are byte addresses.
`default_nettype none

package mgc_pkg;

    // ==========================================================
    // Bus geometry and register map
    localparam int          MGC_ADDR_W        = 12;
    localparam int          MGC_DATA_W        = 32;
    localparam int          MGC_STRB_W        = 4;
    localparam logic [11:0] MGC_OFF_CTRL      = 12'h000;
    localparam logic [11:0] MGC_OFF_IRQ_STAT  = 12'h004;
    localparam logic [11:0] MGC_OFF_IRQ_MASK  = 12'h008;

    // ==========================================================
    // Control register field positions
    localparam int MGC_B_SOFT_RST   = 0;
    localparam int MGC_B_PHY_SEEN   = 1;
    localparam int MGC_B_PHY_PWR    = 2;
    localparam int MGC_B_HW_OWN     = 3;
    localparam int MGC_B_FW_OWN     = 4;
    localparam int MGC_B_INIT_DONE  = 5;
    localparam int MGC_B_CPL_BLK    = 6;
    localparam int MGC_B_WAKE_EN    = 7;
    localparam int MGC_B_RSVD8      = 8;
    localparam int MGC_B_RST_WARN   = 10;
    localparam int MGC_B_RST_SAFE   = 11;

    // ==========================================================
    // Reset values
    localparam logic MGC_RST_SOFT_RST  = 1'b0;
    localparam logic MGC_RST_PHY_SEEN  = 1'b1;
    localparam logic MGC_RST_PHY_PWR   = 1'b1;
    localparam logic MGC_RST_FW_OWN    = 1'b0;
    localparam logic MGC_RST_INIT_DONE = 1'b0;
    localparam logic MGC_RST_CPL_BLK   = 1'b0;
    localparam logic MGC_RST_WAKE_EN   = 1'b0;
    localparam logic MGC_RST_RSVD8     = 1'b0;
    localparam logic MGC_RST_RST_WARN  = 1'b0;
    localparam logic MGC_RST_PIN       = 1'b0;
    localparam logic [4:0]  MGC_RST_IRQ   = 5'h00;
    localparam logic [31:0] MGC_RD_ZERO   = 32'h0000_0000;

    // ==========================================================
    // Interrupt event layout, shared by status and mask registers
    typedef struct packed {
        logic rst_safe;
        logic link_chg;
        logic cpl_blk;
        logic init_done;
        logic phy_rst;
    } mgc_irq_s;

    // ==========================================================
    // Flash quiesce sequence before an engine reset
    typedef enum logic [1:0] {
        QS_IDLE,
        QS_DRAIN,
        QS_SAFE
    } mgc_quiesce_e;

endpackage

`default_nettype wire

// >>> rtl/mgc_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to pclk; output moves only when stages two and three agree.
`default_nettype none

module mgc_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic din,
    output var  logic dout
);

    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic out_r;

    // ==========================================================
    // Stage one feeds stage two only, to keep metastability contained.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_r <= RST_VAL;
        end else if (s2_r == s3_r) begin
            out_r <= s3_r;
        end
    end

    assign dout = out_r;

endmodule

`default_nettype wire

// >>> rtl/mgc_ctrl.sv
// Management general control and status register with APB access and interrupt.
// Assumes pin inputs are asynchronous and all other inputs come from logic on pclk.
`default_nettype none

// Contract
// - Writing one to bit 0 resets the management port state, configuration included, except the firmware semaphore, then clears.
// - The port soft reset touches only management port logic, never host space, MAC or PHY.
// - Bit 1 resets to one, is set while phy side reset is asserted, cleared by writing zero.
// - Bit 2 is a read-only shadow of the PHY power indication that resets to one.
// - Bit 3 reads back the hardware MDIO ownership request input directly, with no register or reset value.
// - Bit 4 always mirrors the firmware semaphore flag and resets to zero.
// - Bit 5 is set when LAN init from flash completes and software clears it for the next event.
// - Bit 6 is set on an erroneous read completion and cleared only by a port reset.
// - With bit 7 set a link status change raises a wake to the engine, otherwise none.
// - After the reset warning bit 10 is set, flash access stops at the next safe point.
// - Bit 11 sets once the warning is set and no flash transaction is pending, and holds until the cycle after the warning clears.
// - The firmware semaphore is granted only when the software flag is clear and MDIO is idle.
module mgc_ctrl (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [mgc_pkg::MGC_ADDR_W-1:0] paddr,
    input  wire logic [mgc_pkg::MGC_DATA_W-1:0] pwdata,
    input  wire logic [mgc_pkg::MGC_STRB_W-1:0] pstrb,
    output var  logic [mgc_pkg::MGC_DATA_W-1:0] prdata,
    output var  logic                        pready,
    output var  logic                        pslverr,
    input  wire logic                        phy_side_reset,
    input  wire logic                        phy_power_up,
    input  wire logic                        link_up,
    input  wire logic                        hw_mdio_own,
    input  wire logic                        hw_mdio_busy,
    input  wire logic                        software_semaphore_flag,
    input  wire logic                        lan_init_done,
    input  wire logic                        cpl_error,
    input  wire logic                        spi_pending,
    output var  logic                        port_soft_reset,
    output var  logic                        firmware_semaphore_flag,
    output var  logic                        engine_reset_warning,
    output var  logic                        engine_reset_safe,
    output var  logic                        engine_wake,
    output var  logic                        irq
);

    // ==========================================================
    // Pin synchronisers
    logic phy_rst_s;
    logic phy_pwr_s;
    logic link_s;

    mgc_sync #(.RST_VAL(mgc_pkg::MGC_RST_PIN)) u_sync_phy_rst (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (phy_side_reset),
        .dout    (phy_rst_s)
    );

    mgc_sync #(.RST_VAL(mgc_pkg::MGC_RST_PHY_PWR)) u_sync_phy_pwr (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (phy_power_up),
        .dout    (phy_pwr_s)
    );

    mgc_sync #(.RST_VAL(mgc_pkg::MGC_RST_PIN)) u_sync_link (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (link_up),
        .dout    (link_s)
    );

    // ==========================================================
    // APB decode
    logic                 setup;
    logic                 wr;
    logic                 hit_ctrl;
    logic                 hit_stat;
    logic                 hit_mask;
    logic                 wr_ctrl;
    logic                 wr_stat;
    logic                 wr_mask;
    logic [31:0]          wmask;
    logic [31:0]          wset;
    logic [31:0]          wclr;

    assign setup    = psel && !penable;
    assign wr       = psel && penable && pwrite;
    assign hit_ctrl = paddr[11:2] == mgc_pkg::MGC_OFF_CTRL[11:2];
    assign hit_stat = paddr[11:2] == mgc_pkg::MGC_OFF_IRQ_STAT[11:2];
    assign hit_mask = paddr[11:2] == mgc_pkg::MGC_OFF_IRQ_MASK[11:2];
    assign wr_ctrl  = wr && hit_ctrl;
    assign wr_stat  = wr && hit_stat;
    assign wr_mask  = wr && hit_mask;
    assign wmask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    // Only lanes that are strobed write ones or zeros; other bits keep their value.
    assign wset     = pwdata & wmask;
    assign wclr     = ~pwdata & wmask;

    // ==========================================================
    // Soft reset of the management port
    logic soft_rst_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_rst_r <= mgc_pkg::MGC_RST_SOFT_RST;
        end else begin
            soft_rst_r <= wr_ctrl && wset[mgc_pkg::MGC_B_SOFT_RST];
        end
    end

    // The pulse goes only to management port logic; host space and PHY are not wired to it.
    assign port_soft_reset = soft_rst_r;

    // ==========================================================
    // Control fields
    logic phy_seen_r;
    logic phy_rst_q_r;
    logic init_done_r;
    logic cpl_blk_r;
    logic wake_en_r;
    logic rsvd8_r;
    logic warn_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_seen_r  <= mgc_pkg::MGC_RST_PHY_SEEN;
            phy_rst_q_r <= mgc_pkg::MGC_RST_PIN;
        end else if (soft_rst_r) begin
            phy_seen_r  <= mgc_pkg::MGC_RST_PHY_SEEN;
            phy_rst_q_r <= phy_rst_s;
        end else begin
            phy_rst_q_r <= phy_rst_s;
            // A reset seen in the clearing cycle is kept.
            if (phy_rst_s) begin
                phy_seen_r <= 1'b1;
            end else if (wr_ctrl && wclr[mgc_pkg::MGC_B_PHY_SEEN]) begin
                phy_seen_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_done_r <= mgc_pkg::MGC_RST_INIT_DONE;
        end else if (soft_rst_r) begin
            init_done_r <= mgc_pkg::MGC_RST_INIT_DONE;
        end else if (lan_init_done) begin
            init_done_r <= 1'b1;
        end else if (wr_ctrl && wclr[mgc_pkg::MGC_B_INIT_DONE]) begin
            init_done_r <= 1'b0;
        end
    end

    // Software cannot clear this flag; only a port reset does.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpl_blk_r <= mgc_pkg::MGC_RST_CPL_BLK;
        end else if (soft_rst_r) begin
            cpl_blk_r <= mgc_pkg::MGC_RST_CPL_BLK;
        end else if (cpl_error) begin
            cpl_blk_r <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_en_r <= mgc_pkg::MGC_RST_WAKE_EN;
            rsvd8_r   <= mgc_pkg::MGC_RST_RSVD8;
            warn_r    <= mgc_pkg::MGC_RST_RST_WARN;
        end else if (soft_rst_r) begin
            wake_en_r <= mgc_pkg::MGC_RST_WAKE_EN;
            rsvd8_r   <= mgc_pkg::MGC_RST_RSVD8;
            warn_r    <= mgc_pkg::MGC_RST_RST_WARN;
        end else if (wr_ctrl) begin
            if (wmask[mgc_pkg::MGC_B_WAKE_EN]) begin
                wake_en_r <= pwdata[mgc_pkg::MGC_B_WAKE_EN];
            end
            if (wmask[mgc_pkg::MGC_B_RSVD8]) begin
                rsvd8_r <= pwdata[mgc_pkg::MGC_B_RSVD8];
            end
            if (wmask[mgc_pkg::MGC_B_RST_WARN]) begin
                warn_r <= pwdata[mgc_pkg::MGC_B_RST_WARN];
            end
        end
    end

    // ==========================================================
    // Firmware MDIO semaphore
    // The semaphore lives with power-good state, so the port soft reset leaves it alone.
    logic fw_req_r;
    logic fw_flag_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fw_req_r <= mgc_pkg::MGC_RST_FW_OWN;
        end else if (wr_ctrl && wmask[mgc_pkg::MGC_B_FW_OWN]) begin
            fw_req_r <= pwdata[mgc_pkg::MGC_B_FW_OWN];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fw_flag_r <= mgc_pkg::MGC_RST_FW_OWN;
        end else if (!fw_req_r) begin
            fw_flag_r <= 1'b0;
        end else if (!fw_flag_r) begin
            fw_flag_r <= !software_semaphore_flag && !hw_mdio_busy;
        end
    end

    assign firmware_semaphore_flag = fw_flag_r;

    // ==========================================================
    // Flash quiesce ahead of an engine reset
    mgc_pkg::mgc_quiesce_e qs_r;
    mgc_pkg::mgc_quiesce_e qs_nxt;

    always_comb begin
        qs_nxt = qs_r;
        case (qs_r)
            mgc_pkg::QS_IDLE: begin
                if (warn_r) begin
                    qs_nxt = mgc_pkg::QS_DRAIN;
                end
            end
            mgc_pkg::QS_DRAIN: begin
                if (!warn_r) begin
                    qs_nxt = mgc_pkg::QS_IDLE;
                end else if (!spi_pending) begin
                    qs_nxt = mgc_pkg::QS_SAFE;
                end
            end
            mgc_pkg::QS_SAFE: begin
                if (!warn_r) begin
                    qs_nxt = mgc_pkg::QS_IDLE;
                end
            end
            default: begin
                qs_nxt = mgc_pkg::QS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qs_r <= mgc_pkg::QS_IDLE;
        end else if (soft_rst_r) begin
            qs_r <= mgc_pkg::QS_IDLE;
        end else begin
            qs_r <= qs_nxt;
        end
    end

    // The flash engine must not start new work while the warning stands.
    assign engine_reset_warning = warn_r;
    assign engine_reset_safe    = qs_r == mgc_pkg::QS_SAFE;

    // ==========================================================
    // Link change wake
    logic link_q_r;
    logic wake_r;
    logic link_chg;

    assign link_chg = link_s ^ link_q_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_q_r <= mgc_pkg::MGC_RST_PIN;
            wake_r   <= 1'b0;
        end else begin
            link_q_r <= link_s;
            wake_r   <= link_chg && wake_en_r;
        end
    end

    assign engine_wake = wake_r;

    // ==========================================================
    // Interrupt status and mask
    mgc_pkg::mgc_irq_s irq_stat_r;
    mgc_pkg::mgc_irq_s irq_mask_r;
    mgc_pkg::mgc_irq_s irq_evt;
    logic              safe_q_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            safe_q_r <= 1'b0;
        end else begin
            safe_q_r <= engine_reset_safe;
        end
    end

    assign irq_evt.phy_rst   = phy_rst_s && !phy_rst_q_r;
    assign irq_evt.init_done = lan_init_done;
    assign irq_evt.cpl_blk   = cpl_error;
    assign irq_evt.link_chg  = link_chg;
    assign irq_evt.rst_safe  = engine_reset_safe && !safe_q_r;

    // Write one clears a status bit, but a new event in the same cycle wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= mgc_pkg::MGC_RST_IRQ;
        end else if (soft_rst_r) begin
            irq_stat_r <= mgc_pkg::MGC_RST_IRQ;
        end else begin
            irq_stat_r <= (irq_stat_r & ~(wr_stat ? wset[4:0] : 5'h00)) | irq_evt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= mgc_pkg::MGC_RST_IRQ;
        end else if (soft_rst_r) begin
            irq_mask_r <= mgc_pkg::MGC_RST_IRQ;
        end else if (wr_mask) begin
            irq_mask_r <= (irq_mask_r & ~wmask[4:0]) | wset[4:0];
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // ==========================================================
    // Read data and response
    logic [31:0] ctrl_rd;
    logic [31:0] rdata_nxt;
    logic [31:0] prdata_r;
    logic        slverr_r;

    always_comb begin
        ctrl_rd                          = mgc_pkg::MGC_RD_ZERO;
        ctrl_rd[mgc_pkg::MGC_B_SOFT_RST]  = soft_rst_r;
        ctrl_rd[mgc_pkg::MGC_B_PHY_SEEN]  = phy_seen_r;
        ctrl_rd[mgc_pkg::MGC_B_PHY_PWR]   = phy_pwr_s;
        ctrl_rd[mgc_pkg::MGC_B_HW_OWN]    = hw_mdio_own;
        ctrl_rd[mgc_pkg::MGC_B_FW_OWN]    = fw_flag_r;
        ctrl_rd[mgc_pkg::MGC_B_INIT_DONE] = init_done_r;
        ctrl_rd[mgc_pkg::MGC_B_CPL_BLK]   = cpl_blk_r;
        ctrl_rd[mgc_pkg::MGC_B_WAKE_EN]   = wake_en_r;
        ctrl_rd[mgc_pkg::MGC_B_RSVD8]     = rsvd8_r;
        ctrl_rd[mgc_pkg::MGC_B_RST_WARN]  = warn_r;
        ctrl_rd[mgc_pkg::MGC_B_RST_SAFE]  = engine_reset_safe;
    end

    always_comb begin
        rdata_nxt = mgc_pkg::MGC_RD_ZERO;
        if (hit_ctrl) begin
            rdata_nxt = ctrl_rd;
        end else if (hit_stat) begin
            rdata_nxt[4:0] = irq_stat_r;
        end else if (hit_mask) begin
            rdata_nxt[4:0] = irq_mask_r;
        end
    end

    // Read data is captured in the setup cycle, so reads see state one cycle before the access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= mgc_pkg::MGC_RD_ZERO;
            slverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r <= pwrite ? mgc_pkg::MGC_RD_ZERO : rdata_nxt;
            slverr_r <= !(hit_ctrl || hit_stat || hit_mask);
        end
    end

    assign prdata  = prdata_r;
    assign pslverr = slverr_r && psel && penable;
    assign pready  = 1'b1;

endmodule

`default_nettype wire

// >>> testbench/mgc_ctrl_asserts.sv
// Concurrent checks on the ports of the management general control block.
// Assumes one pclk domain and the zero-wait APB slave described for the block.
`default_nettype none

module mgc_ctrl_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        hw_mdio_busy,
    input wire logic        software_semaphore_flag,
    input wire logic        spi_pending,
    input wire logic        port_soft_reset,
    input wire logic        firmware_semaphore_flag,
    input wire logic        engine_reset_warning,
    input wire logic        engine_reset_safe,
    input wire logic        engine_wake,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_soft_pulse: assert property (psel && penable && pwrite && paddr[11:2] == 10'h0
        && pstrb[0] && pwdata[0] |=> port_soft_reset ##1 !port_soft_reset)
        else $error("soft reset pulse missing or too long");
    a_irq_soft: assert property (port_soft_reset |=> !irq)
        else $error("interrupt survives soft reset");
    a_safe_rose: assert property ($rose(engine_reset_safe) |->
        $past(engine_reset_warning) && !$past(spi_pending))
        else $error("safe raised without warning or with flash pending");
    a_safe_drop: assert property (engine_reset_safe && !engine_reset_warning |=>
        !engine_reset_safe)
        else $error("safe held after warning cleared");
    a_safe_timely: assert property (engine_reset_warning && !spi_pending ##1
        engine_reset_warning && !spi_pending && !port_soft_reset |=> engine_reset_safe)
        else $error("safe not raised at the idle point");
    a_wake_pulse: assert property (engine_wake |=> !engine_wake)
        else $error("wake longer than one cycle");
    a_sema_grant: assert property ($rose(firmware_semaphore_flag) |->
        !$past(software_semaphore_flag) && !$past(hw_mdio_busy))
        else $error("semaphore granted while blocked");
    a_err_decode: assert property (psel && penable |-> pslverr == (paddr[11:2] > 10'h2))
        else $error("slave error decode wrong");
    a_ready_high: assert property (psel && penable |-> pready)
        else $error("ready low in access phase");
endmodule

bind mgc_ctrl mgc_ctrl_asserts u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .hw_mdio_busy(hw_mdio_busy), .software_semaphore_flag(software_semaphore_flag),
    .spi_pending(spi_pending), .port_soft_reset(port_soft_reset),
    .firmware_semaphore_flag(firmware_semaphore_flag), .irq(irq),
    .engine_reset_warning(engine_reset_warning), .engine_reset_safe(engine_reset_safe),
    .engine_wake(engine_wake));

`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench of the management general control block over APB.
// Assumes the package offsets and a zero-wait slave; a register model lives in m_ctrl.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] CTRL = mgc_pkg::MGC_OFF_CTRL;
    localparam logic [11:0] STAT = mgc_pkg::MGC_OFF_IRQ_STAT;
    localparam logic [11:0] MASK = mgc_pkg::MGC_OFF_IRQ_MASK;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, err_q, own;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_q, m_ctrl, w;
    logic [3:0]  pstrb, s;
    logic        phy_side_reset, phy_power_up, link_up, hw_mdio_own, hw_mdio_busy;
    logic        software_semaphore_flag, lan_init_done, cpl_error, spi_pending;
    logic        port_soft_reset, firmware_semaphore_flag, engine_reset_warning;
    logic        engine_reset_safe, engine_wake, irq;
    int          error_cnt, num_checks, seed, n;

    mgc_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .phy_side_reset(phy_side_reset),
        .phy_power_up(phy_power_up), .link_up(link_up), .hw_mdio_own(hw_mdio_own),
        .hw_mdio_busy(hw_mdio_busy), .software_semaphore_flag(software_semaphore_flag),
        .lan_init_done(lan_init_done), .cpl_error(cpl_error), .spi_pending(spi_pending),
        .port_soft_reset(port_soft_reset), .firmware_semaphore_flag(firmware_semaphore_flag),
        .engine_reset_warning(engine_reset_warning), .engine_reset_safe(engine_reset_safe),
        .engine_wake(engine_wake), .irq(irq));

    always #5 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask

    // The request is held until pready is seen high; read data is taken at that edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] st);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(rd_q, e);
    endtask

    task automatic count_wake(input int e);
        n = 0;
        link_up <= ~link_up;
        repeat (12) begin
            @(posedge pclk);
            n += int'(engine_wake);
        end
        chk(32'(n), 32'(e));
    endtask

    initial begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        summarize();
    end

    initial begin
        seed = $urandom(32'h740ad593);
        {presetn, psel, penable, pwrite, phy_side_reset, link_up, hw_mdio_own} = 7'h0;
        {lan_init_done, cpl_error, paddr, pwdata, pstrb} = 50'h0;
        {phy_power_up, hw_mdio_busy, software_semaphore_flag, spi_pending} = 4'hf;
        own = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        cyc(6);
        m_ctrl = 32'h0000_0006;
        rdc(CTRL, m_ctrl);
        rdc(STAT, 32'h0);
        rdc(MASK, 32'h0);
        apb(1'b1, 12'h00c, 32'hffff_ffff, 4'hf);
        chk({31'h0, err_q}, 32'h1);
        rdc(12'h00c, 32'h0);
        $display("test 1 done");
        // Random writes hold zero in bits 0, 1, 4 and 5: the self-clearing, phy-seen, semaphore and init-done bits.
        for (int i = 0; i < 6; i++) begin
            w = $urandom & ~32'h0000_0033;
            s = 4'($urandom);
            own = 1'($urandom);
            hw_mdio_own <= own;
            apb(1'b1, CTRL, w, s);
            if (s[0]) begin
                m_ctrl[1] = 1'b0;
                m_ctrl[7] = w[7];
            end
            if (s[1]) begin
                m_ctrl[8] = w[8];
                m_ctrl[10] = w[10];
            end
            m_ctrl[3] = own;
            rdc(CTRL, m_ctrl);
        end
        apb(1'b1, CTRL, 32'h0, 4'hf);
        m_ctrl &= 32'h0000_000c;
        $display("test 2 done");
        lan_init_done <= 1'b1;
        cpl_error <= 1'b1;
        @(posedge pclk);
        lan_init_done <= 1'b0;
        cpl_error <= 1'b0;
        cyc(2);
        m_ctrl |= 32'h0000_0060;
        rdc(CTRL, m_ctrl);
        rdc(STAT, 32'h6);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, MASK, 32'h6, 4'hf);
        cyc(1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, STAT, 32'h2, 4'hf);
        rdc(STAT, 32'h4);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, STAT, 32'h4, 4'hf);
        cyc(1);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, CTRL, 32'h0, 4'h1);
        m_ctrl[5] = 1'b0;
        rdc(CTRL, m_ctrl);
        $display("test 3 done");
        phy_side_reset <= 1'b1;
        phy_power_up <= 1'b0;
        cyc(8);
        phy_side_reset <= 1'b0;
        cyc(6);
        m_ctrl[1] = 1'b1;
        m_ctrl[2] = 1'b0;
        rdc(CTRL, m_ctrl);
        phy_power_up <= 1'b1;
        m_ctrl[2] = 1'b1;
        rdc(STAT, 32'h1);
        apb(1'b1, STAT, 32'h1f, 4'hf);
        $display("test 4 done");
        apb(1'b1, CTRL, 32'h400, 4'h2);
        m_ctrl[10] = 1'b1;
        cyc(4);
        chk({31'h0, engine_reset_safe}, 32'h0);
        chk({31'h0, engine_reset_warning}, 32'h1);
        spi_pending <= 1'b0;
        cyc(3);
        chk({31'h0, engine_reset_safe}, 32'h1);
        rdc(CTRL, m_ctrl | 32'h800);
        rdc(STAT, 32'h10);
        apb(1'b1, CTRL, 32'h0, 4'h2);
        m_ctrl[10] = 1'b0;
        cyc(2);
        chk({31'h0, engine_reset_safe}, 32'h0);
        apb(1'b1, STAT, 32'h1f, 4'hf);
        $display("test 5 done");
        apb(1'b1, CTRL, 32'h10, 4'h1);
        m_ctrl[1] = 1'b0;
        cyc(4);
        chk({31'h0, firmware_semaphore_flag}, 32'h0);
        software_semaphore_flag <= 1'b0;
        hw_mdio_busy <= 1'b0;
        cyc(3);
        chk({31'h0, firmware_semaphore_flag}, 32'h1);
        m_ctrl[4] = 1'b1;
        rdc(CTRL, m_ctrl);
        $display("test 6 done");
        apb(1'b1, CTRL, 32'h90, 4'h1);
        count_wake(1);
        apb(1'b1, CTRL, 32'h10, 4'h1);
        count_wake(0);
        rdc(STAT, 32'h8);
        $display("test 7 done");
        apb(1'b1, MASK, 32'h1f, 4'hf);
        cyc(1);
        chk({31'h0, irq}, 32'h1);
        // Soft reset with bit 4 kept high: control fields return to reset values (phy-seen to one), mask and status clear, and the semaphore stays granted.
        apb(1'b1, CTRL, 32'h91, 4'h1);
        cyc(3);
        rdc(CTRL, 32'h16 | {28'h0, own, 3'h0});
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, firmware_semaphore_flag}, 32'h1);
        rdc(MASK, 32'h0);
        rdc(STAT, 32'h0);
        $display("test 8 done");
        summarize();
    end
endmodule

`default_nettype wire
